// ### ide_port_pkg.sv
package ide_port_pkg;

    // -------------------------------------------------------------
    // clock and strobe timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ       = 25;
    localparam int SETUP_NS      = 70;
    localparam int ACTIVE_NS     = 290;
    localparam int RECOVER_NS    = 240;
    // least times round up to whole cycles
    localparam int SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACTIVE_CYC    = (ACTIVE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC   = (RECOVER_NS * CLK_MHZ + 999) / 1000;

    localparam int CNT_W         = 4;
    localparam logic [CNT_W-1:0] SETUP_CNT   = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] ACTIVE_CNT  = CNT_W'(ACTIVE_CYC - 1);
    localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(RECOVER_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;

    // -------------------------------------------------------------
    // widths and fifo
    // -------------------------------------------------------------
    localparam int DATA_W        = 16;
    localparam int ADDR_W        = 3;
    localparam int FIFO_DEPTH    = 8;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 3'h0;

    // -------------------------------------------------------------
    // command kinds, blocks, states
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_REG_RD = 2'b00,
        OP_REG_WR = 2'b01,
        OP_DMA_RD = 2'b10,
        OP_DMA_WR = 2'b11
    } op_t;

    typedef enum logic {
        BLK_CMD  = 1'b0,
        BLK_CTRL = 1'b1
    } blk_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WAITREQ = 3'b001,
        ST_SETUP   = 3'b010,
        ST_ACTIVE  = 3'b011,
        ST_RECOVER = 3'b100
    } phase_t;

    typedef struct packed {
        op_t               op;
        blk_t              blk;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cmd_t;

endpackage

// ### ide_port.sv
// What this block does
// [RULE_01] drive three-bit register address per access
// [RULE_02] command block select low only for it
// [RULE_03] control block select low only for it
// [RULE_04] shared sixteen-bit data bus, direction per transfer
// [RULE_05] address floats in reset, works in suspend
// [RULE_06] data bus floats in reset, works in suspend; a command taken on the edge suspend is synchronised still runs, so a write can drive the bus
// [RULE_07] dma acknowledge marks dma strobe cycles
// [RULE_08] acknowledge only for bus master dma, high idle
// [RULE_09] drive requests dma through its request line
// [RULE_10] pair or master/slave routing, pins serve master
// [RULE_11] read strobe, data taken at its release
// [RULE_12] drive latches write data at strobe release
// [RULE_13] at most one select, none during dma
`timescale 1ns/10ps

// -----------------------------------------------------------------
// read data buffer
// -----------------------------------------------------------------
module ide_rd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0]   cnt;
    } fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_st_t         st_q;
    fifo_st_t         st_d;
    logic             push;
    logic             pop;

    assign in_ready  = (st_q.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data  = mem[st_q.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop)
        begin
            st_d.rd = st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // storage has no reset; empty flags guard stale words
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[st_q.wr] <= in_data;
        end
    end
endmodule

// -----------------------------------------------------------------
// channel sequencer
// -----------------------------------------------------------------
module ide_port
    import ide_port_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // configuration and power state pins
    input  wire logic              route_master_slave,
    input  wire logic              suspend,
    // command port
    input  wire logic              cmd_valid,
    input  wire cmd_t              cmd,
    output logic                   cmd_ready,
    // read data port
    output logic                   rd_valid,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              rd_ready,
    // routing status
    output logic                   master_connector,
    // disk pins
    output logic      [ADDR_W-1:0] disk_reg_addr,
    output logic                   disk_reg_addr_oe,
    output logic                   cmd_block_select_n,
    output logic                   ctrl_block_select_n,
    input  wire logic [DATA_W-1:0] disk_data_bus_in,
    output logic      [DATA_W-1:0] disk_data_bus_out,
    output logic                   disk_data_bus_oe,
    output logic                   disk_read_strobe_n,
    output logic                   disk_write_strobe_n,
    output logic                   disk_dma_ack_n,
    input  wire logic              disk_dma_req
);
    typedef struct packed {
        phase_t            ph;
        logic [CNT_W-1:0]  cnt;
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic              aoe;
        logic              cs1_n;
        logic              cs3_n;
        logic [DATA_W-1:0] dout;
        logic              doe;
        logic              rd_n;
        logic              wr_n;
        logic              ack_n;
        logic              ready;
        logic              push;
        logic [DATA_W-1:0] pdata;
        logic              master;
        logic              req_s1;
        logic              req_s2;
        logic              susp_s1;
        logic              susp_s2;
        logic              rte_s1;
        logic              rte_s2;
        logic [DATA_W-1:0] din_s1;
        logic [DATA_W-1:0] din_s2;
    } st_t;

    localparam st_t ST_RESET = '{
        ph: ST_IDLE, cnt: CNT_ZERO, op: OP_REG_RD, addr: ADDR_ZERO,
        aoe: 1'b0, cs1_n: 1'b1, cs3_n: 1'b1, dout: DATA_ZERO,
        doe: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ack_n: 1'b1, ready: 1'b0,
        push: 1'b0, pdata: DATA_ZERO, master: 1'b1, req_s1: 1'b0,
        req_s2: 1'b0, susp_s1: 1'b0, susp_s2: 1'b0, rte_s1: 1'b0,
        rte_s2: 1'b0, din_s1: DATA_ZERO, din_s2: DATA_ZERO};

    st_t  st_q;
    st_t  st_d;
    logic fifo_in_ready;
    logic is_dma;
    logic is_rd;

    assign is_dma = (st_q.op == OP_DMA_RD) || (st_q.op == OP_DMA_WR);
    assign is_rd  = (st_q.op == OP_REG_RD) || (st_q.op == OP_DMA_RD);

    always_comb
    begin
        st_d         = st_q;
        st_d.push    = 1'b0;
        // pin inputs pass two flip-flops before use
        st_d.req_s1  = disk_dma_req;                            // RULE_09
        st_d.req_s2  = st_q.req_s1;
        st_d.susp_s1 = suspend;
        st_d.susp_s2 = st_q.susp_s1;
        st_d.rte_s1  = route_master_slave;
        st_d.rte_s2  = st_q.rte_s1;
        st_d.din_s1  = disk_data_bus_in;
        st_d.din_s2  = st_q.din_s1;
        // either routing uses these pins for the first connector
        st_d.master  = 1'b1;                                    // RULE_10
        st_d.aoe     = 1'b1;                                    // RULE_05
        st_d.ready   = 1'b0;
        case (st_q.ph)
            ST_IDLE:
            begin
                st_d.cs1_n = 1'b1;
                st_d.cs3_n = 1'b1;
                st_d.ack_n = 1'b1;                              // RULE_08
                st_d.doe   = 1'b0;
                // a read waits for fifo room so no word is dropped
                st_d.ready = ~st_q.susp_s2 & fifo_in_ready;
                if (cmd_valid && st_q.ready)
                begin
                    st_d.ready = 1'b0;
                    st_d.op    = cmd.op;
                    st_d.dout  = cmd.wdata;
                    if (cmd.op == OP_DMA_RD || cmd.op == OP_DMA_WR)
                    begin
                        st_d.ph = ST_WAITREQ;
                    end
                    else
                    begin
                        st_d.addr  = cmd.addr;                  // RULE_01
                        st_d.cs1_n = (cmd.blk != BLK_CMD);      // RULE_02
                        st_d.cs3_n = (cmd.blk != BLK_CTRL);     // RULE_03
                        st_d.doe   = (cmd.op == OP_REG_WR);     // RULE_04
                        st_d.cnt   = SETUP_CNT;
                        st_d.ph    = ST_SETUP;
                    end
                end
            end
            ST_WAITREQ:
            begin
                // dma cycles never carry a block select
                st_d.cs1_n = 1'b1;                              // RULE_13
                st_d.cs3_n = 1'b1;                              // RULE_13
                if (st_q.susp_s2)
                begin
                    st_d.ph = ST_IDLE;
                end
                else if (st_q.req_s2)
                begin
                    st_d.ack_n = 1'b0;                          // RULE_07
                    st_d.doe   = (st_q.op == OP_DMA_WR);        // RULE_06
                    st_d.cnt   = SETUP_CNT;
                    st_d.ph    = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                if (st_q.cnt == CNT_ZERO)
                begin
                    st_d.rd_n = ~is_rd;                         // RULE_11
                    st_d.wr_n = is_rd;
                    st_d.cnt  = ACTIVE_CNT;
                    st_d.ph   = ST_ACTIVE;
                end
                else
                begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end
            end
            ST_ACTIVE:
            begin
                if (st_q.cnt == CNT_ZERO)
                begin
                    // drive latches write data on this release
                    st_d.rd_n = 1'b1;                           // RULE_12
                    st_d.wr_n = 1'b1;
                    st_d.push  = is_rd;                         // RULE_11
                    st_d.pdata = st_q.din_s2;
                    st_d.cnt   = RECOVER_CNT;
                    st_d.ph    = ST_RECOVER;
                end
                else
                begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end
            end
            ST_RECOVER:
            begin
                if (st_q.cnt == CNT_ZERO)
                begin
                    st_d.cs1_n = 1'b1;
                    st_d.cs3_n = 1'b1;
                    st_d.ack_n = 1'b1;
                    st_d.doe   = 1'b0;
                    st_d.ph    = ST_IDLE;
                end
                else
                begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end
            end
            default:
            begin
                st_d.ph = ST_IDLE;
            end
        endcase
        // suspend: selects and acknowledge forced high once the next phase is idle
        // a command taken on this very edge keeps its selects
        if (st_q.susp_s2 && st_d.ph == ST_IDLE)
        begin
            st_d.cs1_n = 1'b1;                                  // RULE_02
            st_d.cs3_n = 1'b1;                                  // RULE_03
            st_d.ack_n = 1'b1;                                  // RULE_08
        end
    end

    // reset floats address and data, holds selects high
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= ST_RESET;                                   // RULE_05
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ide_rd_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (st_q.push),
        .in_data   (st_q.pdata),
        .in_ready  (fifo_in_ready),
        .out_valid (rd_valid),
        .out_data  (rd_data),
        .out_ready (rd_ready)
    );

    assign cmd_ready           = st_q.ready;
    assign master_connector    = st_q.master;
    assign disk_reg_addr       = st_q.addr;
    assign disk_reg_addr_oe    = st_q.aoe;
    assign cmd_block_select_n  = st_q.cs1_n;
    assign ctrl_block_select_n = st_q.cs3_n;
    assign disk_data_bus_out   = st_q.dout;
    assign disk_data_bus_oe    = st_q.doe;                      // RULE_06
    assign disk_read_strobe_n  = st_q.rd_n;
    assign disk_write_strobe_n = st_q.wr_n;
    assign disk_dma_ack_n      = st_q.ack_n;
endmodule

// ### ide_port_asserts.sv
`timescale 1ns/10ps
module ide_port_asserts
    import ide_port_pkg::*;
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              nrst,
    // command port
    input wire logic              cmd_valid,
    input wire cmd_t              cmd,
    input wire logic              cmd_ready,
    input wire logic              master_connector,
    // disk pins
    input wire logic [ADDR_W-1:0] disk_reg_addr,
    input wire logic              disk_reg_addr_oe,
    input wire logic              cmd_block_select_n,
    input wire logic              ctrl_block_select_n,
    input wire logic              disk_data_bus_oe,
    input wire logic              disk_read_strobe_n,
    input wire logic              disk_write_strobe_n,
    input wire logic              disk_dma_ack_n
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wire strobe_n = disk_read_strobe_n & disk_write_strobe_n;
    wire [2:0] quals = {~cmd_block_select_n, ~ctrl_block_select_n,
                        ~disk_dma_ack_n};
    wire reg_take = cmd_valid & cmd_ready & ~cmd.op[1];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_setup;
        strobe_n [*2] ##1 !strobe_n;
    endsequence
    sequence s_active;
        (!strobe_n) [*8] ##1 strobe_n;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_cmd_select: assert property (
        reg_take && cmd.blk == BLK_CMD |=> !cmd_block_select_n
        && ctrl_block_select_n && disk_reg_addr == $past(cmd.addr))
        else $error("command block select or address wrong");
    a_ctrl_select: assert property (
        reg_take && cmd.blk == BLK_CTRL |=> !ctrl_block_select_n
        && cmd_block_select_n && disk_reg_addr == $past(cmd.addr))
        else $error("control block select or address wrong");
    a_one_qualifier: assert property ($onehot0(quals))
        else $error("more than one select or ack low");
    a_strobe_qual: assert property (!strobe_n |-> $onehot(quals))
        else $error("strobe without exactly one qualifier");
    a_reg_setup: assert property (reg_take |-> ##1 s_setup)
        else $error("strobe setup time wrong");
    a_strobe_width: assert property ($fell(strobe_n) |-> s_active)
        else $error("strobe active width wrong");
    a_recover_hold: assert property (
        $rose(strobe_n) |-> (quals != 3'h0) [*6] ##1 quals == 3'h0)
        else $error("recovery hold wrong");
    a_reg_no_ack: assert property (reg_take |=> disk_dma_ack_n [*8])
        else $error("ack in a register access");
    a_write_drive: assert property (
        !disk_write_strobe_n |-> disk_data_bus_oe && disk_read_strobe_n)
        else $error("write strobe with bus released");
    a_read_release: assert property (
        !disk_read_strobe_n |-> !disk_data_bus_oe)
        else $error("device drives bus during read");
    a_addr_drive: assert property (
        $past(nrst) |-> disk_reg_addr_oe)
        else $error("address released after reset");
    a_master_conn: assert property (master_connector)
        else $error("master connector flag low");
endmodule

bind ide_port ide_port_asserts ide_port_asserts_i (
    .clk_sys, .nrst, .cmd_valid, .cmd, .cmd_ready, .master_connector,
    .disk_reg_addr, .disk_reg_addr_oe, .cmd_block_select_n,
    .ctrl_block_select_n, .disk_data_bus_oe, .disk_read_strobe_n,
    .disk_write_strobe_n, .disk_dma_ack_n
);

// ### disk_drive_model.sv
`timescale 1ns/10ps
module disk_drive_model
    import ide_port_pkg::*;
(
    // clock and command pins
    input wire logic              clk_sys,
    input wire logic [ADDR_W-1:0] disk_reg_addr,
    input wire logic              cmd_block_select_n,
    input wire logic              disk_read_strobe_n,
    input wire logic              disk_write_strobe_n,
    input wire logic              disk_dma_ack_n,
    input wire logic              dma_go,
    // data bus halves
    input wire logic [DATA_W-1:0] disk_data_bus_out,
    input wire logic              disk_data_bus_oe,
    output logic      [DATA_W-1:0] disk_data_bus_in,
    output logic                  disk_dma_req
);
    logic [DATA_W-1:0] regs [16];
    logic [DATA_W-1:0] dma_word;
    logic [DATA_W-1:0] last_q = 16'h0000;
    wire  [3:0]        idx = {cmd_block_select_n, disk_reg_addr};
    assign disk_dma_req = dma_go;
    // a released bus shows the inverse of its last value, never a hold
    assign disk_data_bus_in = disk_data_bus_oe ? disk_data_bus_out
        : !disk_read_strobe_n ? (disk_dma_ack_n ? regs[idx] : dma_word)
        : ~last_q;
    always @(posedge clk_sys)
        last_q <= disk_data_bus_in;
    // write data taken as the strobe is released
    always @(posedge disk_write_strobe_n)
    begin
        if (disk_data_bus_oe === 1'b1 && disk_dma_ack_n === 1'b0)
            dma_word <= disk_data_bus_out;
        else if (disk_data_bus_oe === 1'b1)
            regs[idx] <= disk_data_bus_out;
    end
endmodule

// ### tb_ide_port.sv
`timescale 1ns/10ps
module tb_ide_port
    import ide_port_pkg::*;
;
    logic              clk_sys, nrst, route_master_slave, suspend;
    logic              cmd_valid, cmd_ready, rd_valid, rd_ready, dma_go;
    cmd_t              cmd;
    logic [DATA_W-1:0] rd_data, disk_data_bus_in, disk_data_bus_out;
    logic [ADDR_W-1:0] disk_reg_addr;
    logic              master_connector, disk_reg_addr_oe, disk_data_bus_oe;
    logic              cmd_block_select_n, ctrl_block_select_n;
    logic              disk_read_strobe_n, disk_write_strobe_n;
    logic              disk_dma_ack_n, disk_dma_req;
    int                miscompares = 0;
    int                comparisons = 0;
    int                cycles = 0;

    ide_port ide_port_i (
        .clk_sys, .nrst, .route_master_slave, .suspend, .cmd_valid, .cmd,
        .cmd_ready, .rd_valid, .rd_data, .rd_ready, .master_connector,
        .disk_reg_addr, .disk_reg_addr_oe, .cmd_block_select_n,
        .ctrl_block_select_n, .disk_data_bus_in, .disk_data_bus_out,
        .disk_data_bus_oe, .disk_read_strobe_n, .disk_write_strobe_n,
        .disk_dma_ack_n, .disk_dma_req
    );
    disk_drive_model disk_drive_model_i (
        .clk_sys, .disk_reg_addr, .cmd_block_select_n, .disk_read_strobe_n,
        .disk_write_strobe_n, .disk_dma_ack_n, .dma_go, .disk_data_bus_out,
        .disk_data_bus_oe, .disk_data_bus_in, .disk_dma_req
    );
    // ------------------------------------------------------------
    // clock, timeout, shared tasks
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // 23 commands of about 20 cycles each; ceiling leaves wide margin
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            end_of_test;
        end
    end
    task end_of_test;
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input bit ok, input string m);
        comparisons++;
        if (!ok)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task wait_idle;
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(n < 100, "channel did not return to idle");
    endtask
    task send(input op_t op, input blk_t blk, input logic [2:0] a,
              input logic [DATA_W-1:0] w);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd = '{op, blk, a, w};
        wait_idle;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask
    task pop(input logic [DATA_W-1:0] e);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (rd_valid !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(n < 100, "read word never came");
        chk(rd_data === e, "read word wrong");
        rd_ready = 1'b1;
        @(negedge clk_sys);
        rd_ready = 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk(disk_reg_addr_oe === 1'b0, "address driven in reset");
        chk(disk_data_bus_oe === 1'b0, "data driven in reset");
        chk({cmd_block_select_n, ctrl_block_select_n} === 2'h3,
            "select low in reset");
        chk(disk_dma_ack_n === 1'b1, "ack low in reset");
        chk(rd_valid === 1'b0 && cmd_ready === 1'b0, "port busy in reset");
    endtask
    task t_regs;
        for (int i = 0; i < 8; i++)
            send(OP_REG_WR, BLK_CMD, i[2:0], 16'hc0d0 + 16'(i));
        send(OP_REG_WR, BLK_CTRL, 3'h6, 16'h5a3c);
        for (int i = 0; i < 8; i++)
            send(OP_REG_RD, BLK_CMD, i[2:0], DATA_ZERO);
        repeat (30) @(negedge clk_sys);
        chk(cmd_ready === 1'b0, "command taken with buffer full");
        for (int i = 0; i < 8; i++)
            pop(16'hc0d0 + 16'(i));
        @(negedge clk_sys);
        chk(rd_valid === 1'b0, "buffer not empty after drain");
        send(OP_REG_RD, BLK_CTRL, 3'h6, DATA_ZERO);
        pop(16'h5a3c);
    endtask
    task t_dma;
        send(OP_DMA_WR, BLK_CMD, 3'h0, 16'h9e17);
        repeat (10) @(negedge clk_sys);
        chk(disk_dma_ack_n === 1'b1, "ack before request");
        dma_go = 1'b1;
        wait_idle;
        dma_go = 1'b0;
        send(OP_DMA_RD, BLK_CMD, 3'h0, DATA_ZERO);
        dma_go = 1'b1;
        wait_idle;
        dma_go = 1'b0;
        pop(16'h9e17);
        send(OP_REG_RD, BLK_CMD, 3'h0, DATA_ZERO);
        pop(16'hc0d0);
    endtask
    task t_suspend;
        // a dma wait with no request must be dropped by suspend
        send(OP_DMA_RD, BLK_CMD, 3'h0, DATA_ZERO);
        route_master_slave = 1'b1;
        suspend = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(cmd_ready === 1'b0, "command offered in suspend");
        chk(disk_dma_ack_n === 1'b1, "ack low in suspend");
        chk(disk_data_bus_oe === 1'b0, "bus driven in suspend");
        chk(disk_reg_addr_oe === 1'b1, "address lost in suspend");
        chk(cmd_block_select_n === 1'b1, "select low in suspend");
        suspend = 1'b0;
        send(OP_REG_RD, BLK_CTRL, 3'h6, DATA_ZERO);
        pop(16'h5a3c);
        chk(master_connector === 1'b1, "master connector lost");
    endtask
    initial
    begin
        nrst = 1'b0;
        route_master_slave = 1'b0;
        suspend = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        rd_ready = 1'b0;
        dma_go = 1'b0;
        repeat (20) @(negedge clk_sys);
        t_reset;
        nrst = 1'b1;
        t_regs;
        t_dma;
        t_suspend;
        end_of_test;
    end
endmodule
